// >>> bench/byte_mover_props.sv
// Checker on the byte mover link signals.
// Assumes one clock and an active-high async reset.
`timescale 1ns/1ps
`default_nettype none
module byte_mover_props (
    input wire logic       clk_i,     // Clock
    input wire logic       rst_i,     // Reset
    input wire logic [7:0] sfr_rdata, // Read data
    input wire logic       sfr_rd,    // Read strobe
    input wire logic       ram_we,    // RAM write
    input wire logic       ram_re,    // RAM read
    input wire logic [3:0] per_func,  // Function
    input wire logic [1:0] per_lane,  // Lane
    input wire logic       per_we,    // Peripheral write
    input wire logic       per_re,    // Peripheral read
    input wire logic       hold       // Processor owns bus
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Engine yields to processor, moves whole bytes
    a_hold_ram_quiet: assert property (hold |-> !ram_we && !ram_re)
        else $error("RAM strobe under hold");
    a_hold_per_quiet: assert property (hold |-> !per_we && !per_re)
        else $error("peripheral strobe under hold");
    a_fetch_then_put: assert property (ram_re |-> ##[2:300] per_we)
        else $error("RAM byte never delivered");
    a_take_then_store: assert property (per_re |-> ##[2:300] ram_we)
        else $error("peripheral byte never stored");
    a_put_spacing: assert property (per_we |=> !per_we [*2])
        else $error("peripheral writes too close");
    a_fetch_spacing: assert property (ram_re |=> !ram_re [*2])
        else $error("RAM reads too close");
    a_func_legal: assert property ((per_we || per_re)
        |-> per_func <= 4'h8)
        else $error("illegal transfer function");
    a_single_lane: assert property ((per_we || per_re) && per_func > 4'h1
        |-> per_lane == 2'h0)
        else $error("single byte function off lane zero");
    a_rdata_holds: assert property (!$past(sfr_rd)
        |-> $stable(sfr_rdata))
        else $error("read data moved without read");
    // Main traffic kinds
    c_fetch: cover property (ram_re);
    c_take: cover property (per_re);
    c_hold: cover property (hold);
endmodule : byte_mover_props
`default_nettype wire

// >>> bench/test_byte_mover.sv
// Bench joining both byte mover ends over the link.
// Assumes registers read back one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module test_byte_mover;
    logic        clk_i = 0, rst_i = 1, wr = 0, rd = 0, mwe = 0, mre = 0;
    logic [7:0]  adr = 0, wd = 0, rdat, mrd, pd = 8'h5A, md = 0;
    logic [11:0] ma = 0;
    logic [6:0]  req = 0;
    logic        irq;
    logic [7:0]  q[$];
    int          error_cnt = 0, compares = 0, nw = 0;
    byte_mover_if link ();
    byte_mover byte_mover_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .chan_req_i(req), .irq_o(irq), .link(link.engine));
    byte_mover_system byte_mover_system_inst (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(1'b1), .cpu_addr_i(adr), .cpu_wdata_i(wd), .cpu_wr_i(wr),
        .cpu_rd_i(rd), .cpu_rdata_o(rdat), .mem_addr_i(ma), .mem_wdata_i(md),
        .mem_we_i(mwe), .mem_re_i(mre), .mem_rdata_o(mrd), .per_func_o(),
        .per_lane_o(), .per_data_o(), .per_we_o(), .per_re_o(),
        .per_data_i(pd), .link(link.system));
    byte_mover_props byte_mover_props_inst (.clk_i(clk_i), .rst_i(rst_i),
        .sfr_rdata(link.sfr_rdata), .sfr_rd(link.sfr_rd),
        .ram_we(link.ram_we), .ram_re(link.ram_re),
        .per_func(link.per_func), .per_lane(link.per_lane),
        .per_we(link.per_we), .per_re(link.per_re), .hold(link.hold));
    // Clock
    initial forever #50 clk_i = ~clk_i;
    // Record bytes crossing the link
    always @(posedge clk_i)
    begin
        if (link.per_we) q.push_back(link.per_wdata);
        if (link.ram_we) nw++;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp, input string n);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) begin adr <= a; wd <= d; wr <= 1; end
        @(posedge clk_i) wr <= 0;
    endtask : wrr
    task rdr(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i) begin adr <= a; rd <= 1; end
        @(posedge clk_i) rd <= 0;
        #1 chk(rdat, e, "register");
    endtask : rdr
    task mem(input logic [11:0] a, input logic [7:0] d, input logic w);
        @(posedge clk_i) begin ma <= a; md <= d; mwe <= w; mre <= !w; end
        @(posedge clk_i) begin mwe <= 0; mre <= 0; end
        #1 if (!w) chk(mrd, d, "ram");
    endtask : mem
    task conclude;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    // Watchdog
    initial
    begin
        #400000;
        error_cnt++;
        conclude();
    end
    // Tests
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        for (int a = 8'hC9; a <= 8'hD6; a++) rdr(a[7:0], 8'h00);
        $display("reset test done");
        wrr(byte_mover_pkg::ADDR_PTR, 8'h0B);
        rdr(byte_mover_pkg::ADDR_PTR, 8'h03);
        wrr(byte_mover_pkg::ADDR_PTR, 8'hFF);
        rdr(byte_mover_pkg::ADDR_PTR, 8'h03);
        wrr(byte_mover_pkg::ADDR_PTR, 8'h01);
        wrr(byte_mover_pkg::ADDR_CFG, 8'hC3);
        wrr(byte_mover_pkg::ADDR_BASE_LO, 8'h10);
        wrr(byte_mover_pkg::ADDR_BASE_HI, 8'hF1);
        rdr(byte_mover_pkg::ADDR_BASE_HI, 8'h01);
        wrr(byte_mover_pkg::ADDR_SIZE_LO, 8'h04);
        for (int i = 0; i < 4; i++) mem(12'h110 + 12'(i), 8'hA0 + 8'(i), 1);
        wrr(byte_mover_pkg::ADDR_EN, 8'h02);
        req <= 7'h02;
        for (int t = 0; t < 300 && q.size() < 4; t++) @(posedge clk_i);
        req <= 0;
        for (int i = 0; i < 4; i++) chk(q[i], 8'hA0 + 8'(i), "byte");
        rdr(byte_mover_pkg::ADDR_FULL, 8'h02);
        rdr(byte_mover_pkg::ADDR_HALF, 8'h02);
        rdr(byte_mover_pkg::ADDR_BUSY, 8'h00);
        rdr(byte_mover_pkg::ADDR_OFS_LO, 8'h03);
        chk({7'h0, irq}, 8'h01, "irq");
        wrr(byte_mover_pkg::ADDR_FULL, 8'h00);
        wrr(byte_mover_pkg::ADDR_HALF, 8'h00);
        rdr(byte_mover_pkg::ADDR_FULL, 8'h00);
        chk({7'h0, irq}, 8'h00, "irq");
        $display("ram to peripheral test done");
        wrr(byte_mover_pkg::ADDR_PTR, 8'h00);
        wrr(byte_mover_pkg::ADDR_CFG, 8'h04);
        wrr(byte_mover_pkg::ADDR_BASE_LO, 8'h20);
        wrr(byte_mover_pkg::ADDR_OFS_LO, 8'h00);
        wrr(byte_mover_pkg::ADDR_SIZE_LO, 8'h01);
        wrr(byte_mover_pkg::ADDR_EN, 8'h03);
        wrr(byte_mover_pkg::ADDR_BUSY, 8'h01);
        for (int t = 0; t < 300 && nw < 1; t++) @(posedge clk_i);
        mem(12'h020, 8'h5A, 0);
        rdr(byte_mover_pkg::ADDR_FULL, 8'h01);
        wrr(byte_mover_pkg::ADDR_PTR, 8'h01);
        rdr(byte_mover_pkg::ADDR_BASE_LO, 8'h10);
        $display("forced peripheral to ram test done");
        conclude();
    end
endmodule : test_byte_mover
`default_nettype wire

// >>> verilog/byte_mover.sv
// Seven-channel byte mover engine with indirect channel registers.
// Assumes the system side returns read data one cycle after a strobe.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module byte_mover (
    input  wire logic       clk_i,      // System clock
    input  wire logic       rst_i,      // Async reset, high
    input  wire logic       ce_i,       // Clock enable
    input  wire logic [6:0] chan_req_i, // Peripheral requests
    output logic            irq_o,      // Interrupt request
    byte_mover_if.engine    link        // System link
);

    localparam int NCH = byte_mover_pkg::NUM_CHAN;
    localparam logic [NCH-1:0] ONE = {{(NCH-1){1'b0}}, 1'b1};

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_STORE, ST_WRITE}
        state_t;

    logic [7:0]     cfg_ff  [NCH];
    logic [11:0]    base_ff [NCH];
    logic [9:0]     ofs_ff  [NCH];
    logic [9:0]     size_ff [NCH];
    logic [NCH-1:0] wrap_ff;
    logic [NCH-1:0] en_ff;
    logic [NCH-1:0] full_ff;
    logic [NCH-1:0] half_ff;
    logic [NCH-1:0] run_ff;
    logic [NCH-1:0] done_ff;
    logic [2:0]     sel_ff;
    state_t         state_ff;
    logic [2:0]     chan_ff;
    logic [1:0]     lane_ff;
    logic [1:0]     last_lane_ff;
    logic [3:0]     func_ff;
    logic           endian_ff;
    logic [11:0]    addr_ff;
    logic [7:0]     data_ff;
    logic [7:0]     rdata_ff;

    logic           sel_ok_w;
    logic [2:0]     idx_w;
    logic           wr_w;
    logic           ind_wr_w;
    logic [NCH-1:0] cur_w;
    logic [NCH-1:0] busy_w;
    logic [NCH-1:0] elig_w;
    logic [2:0]     pick_w;
    logic           to_ram_w;
    logic           last_w;
    logic [10:0]    mid_w;
    logic           step_w;
    logic           done_w;
    logic           end_w;
    logic [NCH-1:0] stop_w;
    logic [NCH-1:0] force_w;
    logic [NCH-1:0] ofs_wr_w;
    logic [NCH-1:0] full_ie_w;
    logic [NCH-1:0] half_ie_w;

    // Indirect access follows the pointer; code seven reaches nothing
    assign sel_ok_w = (sel_ff != byte_mover_pkg::CHAN_BAD); // R9
    assign idx_w    = sel_ok_w ? sel_ff : 3'h0;
    assign wr_w     = ce_i && link.sfr_wr;
    assign ind_wr_w = wr_w && sel_ok_w; // R10

    // Busy is a forced run or the channel now on the bus
    assign cur_w  = (state_ff != ST_IDLE) ? (ONE << chan_ff) : '0;
    assign busy_w = run_ff | cur_w; // R7

    // Eligible channels and lowest-numbered pick
    always_comb
    begin
        elig_w = en_ff & ~done_ff & (chan_req_i | run_ff); // R1
        for (int c = 0; c < NCH; c++)
        begin
            full_ie_w[c] = cfg_ff[c][byte_mover_pkg::CFG_FULL_IE]; // R3
            half_ie_w[c] = cfg_ff[c][byte_mover_pkg::CFG_HALF_IE]; // R5
            if (cfg_ff[c][byte_mover_pkg::CFG_STALL])
                elig_w[c] = 1'b0; // R13
        end
        pick_w = 3'h0;
        for (int c = NCH - 1; c >= 0; c--)
        begin
            if (elig_w[c])
                pick_w = 3'(c); // R21
        end
    end

    // Direction of the latched function
    assign to_ram_w = (func_ff == byte_mover_pkg::FN_ENC_TO_RAM) ||
                      (func_ff == byte_mover_pkg::FN_SER_TO_RAM) ||
                      (func_ff == byte_mover_pkg::FN_CIPH_TO_RAM); // R15

    // Completion and mid-point of the active channel
    assign last_w = (ofs_ff[chan_ff] == size_ff[chan_ff] - 10'h001); // R2
    assign mid_w  = 11'(({1'b0, size_ff[chan_ff]} + 11'h001) >> 1); // R4
    assign step_w = ce_i && (state_ff == ST_WRITE) && !link.hold; // R22
    assign done_w = step_w && last_w; // R11
    assign end_w  = step_w && (last_w || (lane_ff == last_lane_ff));

    // Per-channel events
    assign stop_w  = (done_w && !wrap_ff[chan_ff]) ? cur_w : '0;
    assign force_w = (wr_w && link.sfr_addr == byte_mover_pkg::ADDR_BUSY)
                   ? link.sfr_wdata[NCH-1:0] : '0; // R8
    assign ofs_wr_w = (ind_wr_w && !busy_w[idx_w] &&
                       (link.sfr_addr == byte_mover_pkg::ADDR_OFS_LO ||
                        link.sfr_addr == byte_mover_pkg::ADDR_OFS_HI))
                    ? (ONE << idx_w) : '0;

    // Link strobes, gated by processor hold
    assign link.ram_addr  = addr_ff; // R17
    assign link.ram_wdata = data_ff;
    assign link.per_wdata = data_ff;
    assign link.per_func  = func_ff;
    assign link.per_lane  = endian_ff ? (last_lane_ff - lane_ff)
                                      : lane_ff; // R14
    assign link.ram_re = ce_i && (state_ff == ST_FETCH) && !to_ram_w &&
                         !link.hold;
    assign link.per_re = ce_i && (state_ff == ST_FETCH) && to_ram_w &&
                         !link.hold;
    assign link.ram_we = step_w && to_ram_w;
    assign link.per_we = step_w && !to_ram_w;
    assign link.sfr_rdata = rdata_ff;

    // Interrupt from any enabled flag
    assign irq_o = |((full_ff & full_ie_w) | (half_ff & half_ie_w)); // R24

    // Transfer sequencer
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_ff     <= ST_IDLE;
            chan_ff      <= 3'h0;
            lane_ff      <= 2'h0;
            last_lane_ff <= 2'h0;
            func_ff      <= 4'h0;
            endian_ff    <= 1'b0;
            addr_ff      <= 12'h000;
            data_ff      <= 8'h00;
        end
        else if (ce_i)
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (|elig_w)
                    begin
                        chan_ff   <= pick_w; // R21
                        lane_ff   <= 2'h0;
                        func_ff   <= cfg_ff[pick_w][3:0]; // R15
                        endian_ff <= cfg_ff[pick_w][byte_mover_pkg::CFG_ENDIAN];
                        last_lane_ff <=
                            (cfg_ff[pick_w][3:0] ==
                             byte_mover_pkg::FN_RAM_TO_ENC ||
                             cfg_ff[pick_w][3:0] ==
                             byte_mover_pkg::FN_ENC_TO_RAM)
                            ? byte_mover_pkg::ENC_LAST_LANE
                            : byte_mover_pkg::BYTE_LAST_LANE;
                        addr_ff <= base_ff[pick_w] +
                                   {2'h0, ofs_ff[pick_w]}; // R16 R17
                        state_ff <= ST_FETCH;
                    end
                end
                ST_FETCH:
                begin
                    if (!link.hold)
                        state_ff <= ST_STORE; // R22
                end
                ST_STORE:
                begin
                    data_ff  <= to_ram_w ? link.per_rdata : link.ram_rdata;
                    state_ff <= ST_WRITE;
                end
                ST_WRITE:
                begin
                    if (end_w)
                        state_ff <= ST_IDLE; // R21
                    else if (step_w)
                    begin
                        lane_ff  <= lane_ff + 2'h1;
                        addr_ff  <= addr_ff + 12'h001;
                        state_ff <= ST_FETCH;
                    end
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // Offset counter, base and size of each channel
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                base_ff[c] <= 12'h000;
                ofs_ff[c]  <= 10'h000;
                size_ff[c] <= 10'h000;
            end
        end
        else
        begin
            for (int c = 0; c < NCH; c++)
            begin
                if (step_w && chan_ff == 3'(c))
                begin
                    if (last_w)
                        ofs_ff[c] <= wrap_ff[c] ? 10'h000 : ofs_ff[c]; // R12
                    else
                        ofs_ff[c] <= ofs_ff[c] + 10'h001; // R17
                end
                else if (ind_wr_w && idx_w == 3'(c) && !busy_w[c]) // R23
                begin
                    case (link.sfr_addr)
                        byte_mover_pkg::ADDR_BASE_LO:
                            base_ff[c][7:0] <= link.sfr_wdata; // R16
                        byte_mover_pkg::ADDR_BASE_HI:
                            base_ff[c][11:8] <= link.sfr_wdata[3:0]; // R20
                        byte_mover_pkg::ADDR_OFS_LO:
                            ofs_ff[c][7:0] <= link.sfr_wdata;
                        byte_mover_pkg::ADDR_OFS_HI:
                            ofs_ff[c][9:8] <= link.sfr_wdata[1:0];
                        byte_mover_pkg::ADDR_SIZE_LO:
                            size_ff[c][7:0] <= link.sfr_wdata; // R19
                        byte_mover_pkg::ADDR_SIZE_HI:
                            size_ff[c][9:8] <= link.sfr_wdata[1:0];
                        default:
                            ;
                    endcase
                end
            end
        end
    end

    // Configuration and wrap mode of each channel
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int c = 0; c < NCH; c++)
                cfg_ff[c] <= byte_mover_pkg::REG_RESET;
            wrap_ff <= '0;
        end
        else if (ind_wr_w)
        begin
            if (link.sfr_addr == byte_mover_pkg::ADDR_CFG)
                cfg_ff[idx_w] <= link.sfr_wdata; // R10 R13
            if (link.sfr_addr == byte_mover_pkg::ADDR_MODE)
                wrap_ff[idx_w] <= link.sfr_wdata[byte_mover_pkg::MODE_WRAP];
        end
    end

    // Pointer and enables
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sel_ff <= 3'h0;
            en_ff  <= '0;
        end
        else if (wr_w)
        begin
            if (link.sfr_addr == byte_mover_pkg::ADDR_PTR)
                sel_ff <= link.sfr_wdata[2:0]; // R9
            if (link.sfr_addr == byte_mover_pkg::ADDR_EN)
                en_ff <= link.sfr_wdata[NCH-1:0]; // R1 R20
        end
    end

    // Sticky flags, forced runs and completion; set wins over clear
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            full_ff <= '0;
            half_ff <= '0;
            run_ff  <= '0;
            done_ff <= '0;
        end
        else if (ce_i)
        begin
            full_ff <= (full_ff &
                ~((wr_w && link.sfr_addr == byte_mover_pkg::ADDR_FULL)
                  ? ~link.sfr_wdata[NCH-1:0] : '0))
                | (done_w ? cur_w : '0); // R2 R6
            half_ff <= (half_ff &
                ~((wr_w && link.sfr_addr == byte_mover_pkg::ADDR_HALF)
                  ? ~link.sfr_wdata[NCH-1:0] : '0))
                | ((step_w && {1'b0, ofs_ff[chan_ff]} == mid_w)
                   ? cur_w : '0); // R4 R6
            run_ff  <= (run_ff & ~stop_w) | force_w; // R8
            done_ff <= (done_ff & ~(force_w | ofs_wr_w)) | stop_w; // R11
        end
    end

    // Register read data, one cycle after the strobe
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_ff <= byte_mover_pkg::REG_RESET;
        else if (ce_i && link.sfr_rd)
        begin
            case (link.sfr_addr)
                byte_mover_pkg::ADDR_CFG:
                    rdata_ff <= sel_ok_w ? cfg_ff[idx_w] : 8'h00;
                byte_mover_pkg::ADDR_BASE_LO:
                    rdata_ff <= sel_ok_w ? base_ff[idx_w][7:0] : 8'h00;
                byte_mover_pkg::ADDR_BASE_HI:
                    rdata_ff <= sel_ok_w ? {4'h0, base_ff[idx_w][11:8]}
                                         : 8'h00; // R20
                byte_mover_pkg::ADDR_OFS_LO:
                    rdata_ff <= sel_ok_w ? ofs_ff[idx_w][7:0] : 8'h00;
                byte_mover_pkg::ADDR_OFS_HI:
                    rdata_ff <= sel_ok_w ? {6'h00, ofs_ff[idx_w][9:8]}
                                         : 8'h00;
                byte_mover_pkg::ADDR_SIZE_LO:
                    rdata_ff <= sel_ok_w ? size_ff[idx_w][7:0] : 8'h00;
                byte_mover_pkg::ADDR_SIZE_HI:
                    rdata_ff <= sel_ok_w ? {6'h00, size_ff[idx_w][9:8]}
                                         : 8'h00;
                byte_mover_pkg::ADDR_MODE:
                    rdata_ff <= sel_ok_w ? {7'h00, wrap_ff[idx_w]} : 8'h00;
                byte_mover_pkg::ADDR_PTR:  rdata_ff <= {5'h00, sel_ff};
                byte_mover_pkg::ADDR_EN:   rdata_ff <= {1'b0, en_ff};
                byte_mover_pkg::ADDR_FULL: rdata_ff <= {1'b0, full_ff};
                byte_mover_pkg::ADDR_HALF: rdata_ff <= {1'b0, half_ff};
                byte_mover_pkg::ADDR_BUSY: rdata_ff <= {1'b0, busy_w}; // R7
                default:                   rdata_ff <= 8'h00;
            endcase
        end
    end

endmodule : byte_mover

`default_nettype wire

// >>> verilog/byte_mover_if.sv
// Link between the byte mover engine and its system side.
// Assumes one clock; the system side arbitrates RAM and bus.
`timescale 1ns/1ps
`default_nettype none

interface byte_mover_if;
    logic [7:0]  sfr_addr;   // Register address
    logic [7:0]  sfr_wdata;  // Register write data
    logic        sfr_wr;     // Register write strobe
    logic        sfr_rd;     // Register read strobe
    logic [7:0]  sfr_rdata;  // Register read data, next cycle
    logic [11:0] ram_addr;   // Engine RAM address
    logic [7:0]  ram_wdata;  // Engine RAM write data
    logic        ram_we;     // Engine RAM write
    logic        ram_re;     // Engine RAM read
    logic [7:0]  ram_rdata;  // RAM data, cycle after read
    logic [3:0]  per_func;   // Transfer function
    logic [1:0]  per_lane;   // Peripheral byte lane
    logic [7:0]  per_wdata;  // Byte to peripheral
    logic        per_we;     // Peripheral write
    logic        per_re;     // Peripheral read
    logic [7:0]  per_rdata;  // Peripheral data, cycle after read
    logic        hold;       // Processor owns bus or RAM

    modport engine (
        input  sfr_addr, sfr_wdata, sfr_wr, sfr_rd, ram_rdata,
        input  per_rdata, hold,
        output sfr_rdata, ram_addr, ram_wdata, ram_we, ram_re,
        output per_func, per_lane, per_wdata, per_we, per_re
    );

    modport system (
        output sfr_addr, sfr_wdata, sfr_wr, sfr_rd, ram_rdata,
        output per_rdata, hold,
        input  sfr_rdata, ram_addr, ram_wdata, ram_we, ram_re,
        input  per_func, per_lane, per_wdata, per_we, per_re
    );
endinterface : byte_mover_if

`default_nettype wire

// >>> verilog/byte_mover_pkg.sv
// Constants shared by both ends of the seven-channel byte mover.
// Assumes both ends run on one system clock with one reset.
//
// Operation
// R1 - Per-channel enable bit gates data movement
// R2 - Full flag when offset equals size minus one
// R3 - Config bit 7 enables full-length interrupt
// R4 - Mid flag at half size, odd rounds up
// R5 - Config bit 6 enables mid-point interrupt
// R6 - Flags stay set until software clears
// R7 - Busy bit reads one while channel transfers
// R8 - Writing busy one forces transfer start
// R9 - Three-bit pointer, code seven is invalid
// R10 - Indirect registers follow the channel pointer
// R11 - Offset counts zero to size minus one
// R12 - Wrap bit returns offset to zero
// R13 - Stall bit blocks new transfers until cleared
// R14 - Endian bit orders multi-byte transfers
// R15 - Config bits 3:0 pick transfer function
// R16 - Twelve-bit base address is start address
// R17 - Offset increments per byte, address base+offset
// R18 - Software zeroes offset before a transfer
// R19 - Ten-bit size gives maximum byte count
// R20 - Unused register bits read zero
// R21 - Lowest channel wins at transaction boundaries
// R22 - Processor access makes engine wait
// R23 - Size, base, offset writes ignored while busy
// R24 - Interrupt when enabled flag is set

package byte_mover_pkg;

    localparam int         NUM_CHAN    = 7;
    localparam logic [2:0] CHAN_BAD    = 3'h7;
    localparam int         RAM_AW      = 12;
    localparam int         RAM_DEPTH   = 4096;
    localparam int         OFS_W       = 10;

    // Register offsets on the special-function bus
    localparam logic [7:0] ADDR_CFG     = 8'hC9;
    localparam logic [7:0] ADDR_BASE_LO = 8'hCA;
    localparam logic [7:0] ADDR_BASE_HI = 8'hCB;
    localparam logic [7:0] ADDR_OFS_LO  = 8'hCC;
    localparam logic [7:0] ADDR_OFS_HI  = 8'hCD;
    localparam logic [7:0] ADDR_SIZE_LO = 8'hCE;
    localparam logic [7:0] ADDR_SIZE_HI = 8'hCF;
    localparam logic [7:0] ADDR_PTR     = 8'hD1;
    localparam logic [7:0] ADDR_EN      = 8'hD2;
    localparam logic [7:0] ADDR_FULL    = 8'hD3;
    localparam logic [7:0] ADDR_HALF    = 8'hD4;
    localparam logic [7:0] ADDR_BUSY    = 8'hD5;
    localparam logic [7:0] ADDR_MODE    = 8'hD6;
    localparam logic [7:0] REG_RESET    = 8'h00;

    // Field positions
    localparam int CFG_FULL_IE = 7;
    localparam int CFG_HALF_IE = 6;
    localparam int CFG_STALL   = 5;
    localparam int CFG_ENDIAN  = 4;
    localparam int MODE_WRAP   = 0;

    // Transfer function codes
    localparam logic [3:0] FN_RAM_TO_ENC  = 4'h0;
    localparam logic [3:0] FN_ENC_TO_RAM  = 4'h1;
    localparam logic [3:0] FN_RAM_TO_CRC  = 4'h2;
    localparam logic [3:0] FN_RAM_TO_SER  = 4'h3;
    localparam logic [3:0] FN_SER_TO_RAM  = 4'h4;
    localparam logic [3:0] FN_RAM_TO_KEY  = 4'h5;
    localparam logic [3:0] FN_RAM_TO_BLK  = 4'h6;
    localparam logic [3:0] FN_RAM_TO_XOR  = 4'h7;
    localparam logic [3:0] FN_CIPH_TO_RAM = 4'h8;

    // Last byte lane of a transaction
    localparam logic [1:0] ENC_LAST_LANE  = 2'h2;
    localparam logic [1:0] BYTE_LAST_LANE = 2'h0;

endpackage : byte_mover_pkg

// >>> verilog/byte_mover_system.sv
// System end: processor bus, expanded RAM and peripheral lanes.
// Assumes the processor side drives plain one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none

module byte_mover_system (
    input  wire logic        clk_i,       // System clock
    input  wire logic        rst_i,       // Async reset, high
    input  wire logic        ce_i,        // Clock enable
    input  wire logic [7:0]  cpu_addr_i,  // Register address
    input  wire logic [7:0]  cpu_wdata_i, // Register write data
    input  wire logic        cpu_wr_i,    // Register write
    input  wire logic        cpu_rd_i,    // Register read
    output logic      [7:0]  cpu_rdata_o, // Register read data
    input  wire logic [11:0] mem_addr_i,  // Processor RAM address
    input  wire logic [7:0]  mem_wdata_i, // Processor RAM data
    input  wire logic        mem_we_i,    // Processor RAM write
    input  wire logic        mem_re_i,    // Processor RAM read
    output logic      [7:0]  mem_rdata_o, // RAM data, next cycle
    output logic      [3:0]  per_func_o,  // Transfer function
    output logic      [1:0]  per_lane_o,  // Byte lane
    output logic      [7:0]  per_data_o,  // Byte to peripheral
    output logic             per_we_o,    // Peripheral write
    output logic             per_re_o,    // Peripheral read
    input  wire logic [7:0]  per_data_i,  // Byte from peripheral
    byte_mover_if.system     link         // Engine link
);

    logic [7:0] mem [byte_mover_pkg::RAM_DEPTH];
    logic [7:0] ram_q_ff;
    logic [7:0] per_q_ff;
    logic       bad_ptr_w;

    // Pointer writes of the invalid code never reach the engine
    assign bad_ptr_w = (cpu_addr_i == byte_mover_pkg::ADDR_PTR) &&
                       (cpu_wdata_i[2:0] == byte_mover_pkg::CHAN_BAD); // R9

    // Register bus passes straight through, except the write strobe, gated by bad_ptr_w
    assign link.sfr_addr  = cpu_addr_i;
    assign link.sfr_wdata = cpu_wdata_i;
    assign link.sfr_wr    = cpu_wr_i && !bad_ptr_w;
    assign link.sfr_rd    = cpu_rd_i;
    assign cpu_rdata_o    = link.sfr_rdata;

    // Any processor access stalls the engine
    assign link.hold = cpu_wr_i || cpu_rd_i || mem_we_i || mem_re_i; // R22

    // Peripheral strobes and engine data
    assign per_func_o = link.per_func;
    assign per_lane_o = link.per_lane;
    assign per_data_o = link.per_wdata;
    assign per_we_o   = link.per_we;
    assign per_re_o   = link.per_re;

    // RAM writes, processor first
    always_ff @(posedge clk_i)
    begin
        if (ce_i)
        begin
            if (mem_we_i)
                mem[mem_addr_i] <= mem_wdata_i; // R22
            else if (link.ram_we)
                mem[link.ram_addr] <= link.ram_wdata;
        end
    end

    // RAM read port, processor first
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            ram_q_ff <= byte_mover_pkg::REG_RESET;
        else if (ce_i && mem_re_i)
            ram_q_ff <= mem[mem_addr_i];
        else if (ce_i && link.ram_re)
            ram_q_ff <= mem[link.ram_addr];
    end

    // Peripheral byte captured on engine read
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            per_q_ff <= byte_mover_pkg::REG_RESET;
        else if (ce_i && link.per_re)
            per_q_ff <= per_data_i;
    end

    assign link.ram_rdata = ram_q_ff;
    assign link.per_rdata = per_q_ff;
    assign mem_rdata_o    = ram_q_ff;

endmodule : byte_mover_system

`default_nettype wire
